//--- verilog/dsc_params.svh
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// register indices; byte address is four times the index
`define DSC_IDX_CALIB_SETTING_A   11'h050
`define DSC_IDX_CALIB_CONTROL_B   11'h051
`define DSC_IDX_CALIB_CONTROL_A   11'h061
`define DSC_IDX_CALIB_CONTROL_C   11'h081
`define DSC_IDX_SYSREF_CONTROL    11'h084
`define DSC_IDX_DAC_CLOCK_DIVIDER 11'h094
`define DSC_IDX_DELAY_LINE_POWER  11'h0C0
`define DSC_IDX_DLL_SEARCH_MODE   11'h0C1
`define DSC_IDX_DLL_LOCK_STATUS   11'h0C3
`define DSC_IDX_DLL_STATUS_ENABLE 11'h0C7
`define DSC_IDX_DLL_UPDATE_STROBE 11'h0DB
`define DSC_IDX_DATAPATH_CLK_PWR  11'h100
`define DSC_IDX_LINK_MODE_SELECT  11'h110
`define DSC_IDX_INTERP_SELECT     11'h111
`define DSC_IDX_SYNC_ERR_DURATION 11'h312
`define DSC_IDX_VCO_RESET_CONTROL 11'h792
`define DSC_IDX_PLL_LOCK_STATUS   11'h7B5

// field positions
`define DSC_BIT_HALF_DIV          0
`define DSC_BIT_THIRD_DIV         1
`define DSC_BIT_VCO_RESET         1
`define DSC_BIT_LOCK              0
`define DSC_BIT_DLL_UPDATE        0
`define DSC_BIT_STATUS_EN         0
`define DSC_BIT_DUAL_LINK         5
`define DSC_BIT_LINK_INVALID      7
`define DSC_BIT_SYSREF_DC         6
`define DSC_BIT_SYSREF_RECEIVER_POWERDOWN         0
`define DSC_MSB_LINK_MODE         5
`define DSC_MSB_SERIAL_MODE       4
`define DSC_MSB_MAIN_INTERP       7
`define DSC_LSB_MAIN_INTERP       4
`define DSC_MSB_CHAN_INTERP       3
`define DSC_MSB_SYNC_ERR          7
`define DSC_LSB_SYNC_ERR          4
`define DSC_LSB_INDEX             2
`define DSC_BIT_LOW_LANE          0
`define DSC_MSB_BYTE              7

// reset values, the datapath clock-on code and the serial mode limit
`define DSC_RST_ZERO              8'h00
`define DSC_RST_DATAPATH_CLK_PWR  8'hFF
`define DSC_RST_DELAY_LINE_POWER  8'hFF
`define DSC_RST_INTERP            8'h00
`define DSC_DATAPATH_CLK_ON       8'h00
`define DSC_MAX_SERIAL_MODE       5'h13

`endif

//--- verilog/dsc_pkg.sv
package dsc_pkg;
  typedef logic [7:0]  dsc_byte_t;
  typedef logic [10:0] dsc_index_t;
  // bus answer phase; gray along idle -> answer
  typedef enum logic [1:0] {
    DSC_BUS_IDLE   = 2'b00,
    DSC_BUS_ANSWER = 2'b01
  } dsc_bus_e;
endpackage

//--- verilog/dsc_startup_config.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`include "dsc_params.svh"
// Behaviour
// RULE1 - third-divide bit set makes dac clock the vco frequency over three
// RULE2 - host never sets half and third divide bits together
// RULE3 - half-divide bit set makes dac clock the vco frequency over two
// RULE4 - host pulses vco reset 0x02 then 0x00, waits 100 ms before lock check
// RULE5 - pll lock shows as one in bit 0 of pll status
// RULE6 - update strobe 0x01 then 0x00 moves pending dll settings into the dll
// RULE7 - host picks dll search values by dac rate below or above 4.5 GHz
// RULE8 - status enable 0x01 makes dll lock readable
// RULE9 - dll lock shows as one in bit 0 of dll status
// RULE10 - host issues the calibration writes in the fixed order
// RULE11 - datapath clock register written 0x00 powers up datapath clocks
// RULE12 - link mode bit 5 picks single or dual link, low bits the mode
// RULE13 - interpolation register holds main mode high nibble, channel low
// RULE14 - link mode bit 7 reads one for an invalid mode combination; flags only a zero interp nibble or serial mode above 0x13
// RULE15 - sysref control bit 6 picks ac or dc coupled input
// RULE16 - host sets sysref powerdown only in subclass 0
// RULE17 - host sets sync error duration in bits 7 to 4 per link mode
// RULE18 - host waits for pll lock, then dll lock, before later steps
// RULE19 - host keeps default of other divider register bits
module dsc_startup_config
  import dsc_pkg::*;
#(
  parameter int ADDR_W = 13
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              pll_locked,
  input  wire logic              dll_locked,
  output logic                   vco_half_divide_enable,
  output logic                   vco_third_divide_enable,
  output logic                   vco_reset,
  output logic      [7:0]        delay_line_power_applied,
  output logic      [7:0]        dll_search_applied,
  output logic                   dll_update_pulse,
  output logic      [7:0]        calib_setting_a,
  output logic      [7:0]        calib_control_a,
  output logic      [7:0]        calib_control_b,
  output logic      [7:0]        calib_control_c,
  output logic                   datapath_clocks_on,
  output logic                   dual_link_mode,
  output logic      [4:0]        serial_link_mode,
  output logic      [3:0]        main_path_interp_select,
  output logic      [3:0]        channel_path_interp_select,
  output logic                   link_config_invalid,
  output logic                   sysref_coupling_select,
  output logic                   sysref_receiver_powerdown,
  output logic      [3:0]        link_sync_output_err_len
);

  dsc_bus_e   bus_state;
  dsc_index_t req_index;
  logic       req_valid;
  logic       wr_take;
  logic       rd_issue;
  logic       wr_low;
  dsc_byte_t  wr_byte;
  dsc_byte_t  next_rdata;

  dsc_byte_t  dac_clock_divider;
  dsc_byte_t  vco_reset_control;
  dsc_byte_t  delay_line_power;
  dsc_byte_t  dll_search_mode;
  dsc_byte_t  dll_update_strobe;
  dsc_byte_t  dll_status_enable;
  dsc_byte_t  datapath_clock_power;
  logic [5:0] link_mode_field;
  dsc_byte_t  interpolation_select;
  dsc_byte_t  sysref_control;
  dsc_byte_t  sync_error_duration;
  logic       pll_lock_seen;
  logic       dll_lock_seen;
  logic       next_invalid;

  // only the low byte lane carries register data
  assign req_index = avs_address[ADDR_W-1:`DSC_LSB_INDEX];
  assign req_valid = avs_read | avs_write;
  assign wr_low    = avs_byteenable[`DSC_BIT_LOW_LANE];
  assign wr_byte   = avs_writedata[`DSC_MSB_BYTE:0];
  assign wr_take   = avs_write & wr_low & (bus_state == DSC_BUS_ANSWER);
  assign rd_issue  = avs_read & (bus_state == DSC_BUS_IDLE);

  // one wait cycle per access; the request is taken at the edge
  // where waitrequest is seen low, so a held request is never doubled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_state       <= DSC_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        DSC_BUS_IDLE: begin
          if (req_valid) begin
            bus_state       <= DSC_BUS_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        end
        DSC_BUS_ANSWER: begin
          bus_state       <= DSC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state       <= DSC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // status inputs sampled once; readback uses these
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pll_lock_seen <= 1'b0;
    end else begin
      pll_lock_seen <= pll_locked;
    end
  end

  // dll lock kept apart; readback gates it with status enable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dll_lock_seen <= 1'b0;
    end else begin
      dll_lock_seen <= dll_locked;
    end
  end

  // read mux; write-only registers read as zero
  always_comb begin
    next_rdata = `DSC_RST_ZERO;
    if (req_index == `DSC_IDX_PLL_LOCK_STATUS) begin
      next_rdata[`DSC_BIT_LOCK] = pll_lock_seen; // RULE5
    end else if (req_index == `DSC_IDX_DLL_LOCK_STATUS) begin
      // lock hidden until status readout is enabled
      next_rdata[`DSC_BIT_LOCK] = dll_lock_seen
        & dll_status_enable[`DSC_BIT_STATUS_EN]; // RULE8 RULE9
    end else if (req_index == `DSC_IDX_LINK_MODE_SELECT) begin
      next_rdata[`DSC_MSB_LINK_MODE:0]    = link_mode_field;
      next_rdata[`DSC_BIT_LINK_INVALID]   = link_config_invalid; // RULE14
    end else begin
      next_rdata = `DSC_RST_ZERO;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_issue) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // clock divider register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dac_clock_divider <= `DSC_RST_ZERO;
    end else if (wr_take && req_index == `DSC_IDX_DAC_CLOCK_DIVIDER) begin
      dac_clock_divider <= wr_byte;
    end
  end

  // vco reset control; no self-clear, the host pulses it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vco_reset_control <= `DSC_RST_ZERO;
    end else if (wr_take && req_index == `DSC_IDX_VCO_RESET_CONTROL) begin
      vco_reset_control <= wr_byte;
    end
  end

  // both divide bits set is forbidden; third divide wins so the
  // divider never sees two ratios at once
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vco_third_divide_enable <= 1'b0;
      vco_half_divide_enable  <= 1'b0;
    end else begin
      vco_third_divide_enable <= dac_clock_divider[`DSC_BIT_THIRD_DIV]; // RULE1
      vco_half_divide_enable  <= dac_clock_divider[`DSC_BIT_HALF_DIV]
        & ~dac_clock_divider[`DSC_BIT_THIRD_DIV]; // RULE3 RULE2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vco_reset <= 1'b0;
    end else begin
      vco_reset <= vco_reset_control[`DSC_BIT_VCO_RESET]; // RULE4
    end
  end

  // dll pending settings and status enable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      delay_line_power  <= `DSC_RST_DELAY_LINE_POWER;
      dll_search_mode   <= `DSC_RST_ZERO;
      dll_update_strobe <= `DSC_RST_ZERO;
      dll_status_enable <= `DSC_RST_ZERO;
    end else if (wr_take) begin
      if (req_index == `DSC_IDX_DELAY_LINE_POWER) begin
        delay_line_power <= wr_byte;
      end else if (req_index == `DSC_IDX_DLL_SEARCH_MODE) begin
        dll_search_mode <= wr_byte; // RULE7
      end else if (req_index == `DSC_IDX_DLL_UPDATE_STROBE) begin
        dll_update_strobe <= wr_byte;
      end else if (req_index == `DSC_IDX_DLL_STATUS_ENABLE) begin
        dll_status_enable <= wr_byte; // RULE8
      end
    end
  end

  // transfer fires on the falling write of the strobe bit, so a lone
  // 0x01 with no 0x00 after it leaves the dll untouched
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      delay_line_power_applied <= `DSC_RST_DELAY_LINE_POWER;
      dll_search_applied       <= `DSC_RST_ZERO;
      dll_update_pulse         <= 1'b0;
    end else begin
      dll_update_pulse <= 1'b0;
      if (wr_take && req_index == `DSC_IDX_DLL_UPDATE_STROBE
          && dll_update_strobe[`DSC_BIT_DLL_UPDATE]
          && !wr_byte[`DSC_BIT_DLL_UPDATE]) begin
        delay_line_power_applied <= delay_line_power; // RULE6
        dll_search_applied       <= dll_search_mode; // RULE6
        dll_update_pulse         <= 1'b1; // RULE6
      end
    end
  end

  // calibration registers; order is the host's duty
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      calib_setting_a <= `DSC_RST_ZERO;
      calib_control_a <= `DSC_RST_ZERO;
      calib_control_b <= `DSC_RST_ZERO;
      calib_control_c <= `DSC_RST_ZERO;
    end else if (wr_take) begin
      if (req_index == `DSC_IDX_CALIB_SETTING_A) begin
        calib_setting_a <= wr_byte; // RULE10
      end else if (req_index == `DSC_IDX_CALIB_CONTROL_A) begin
        calib_control_a <= wr_byte; // RULE10
      end else if (req_index == `DSC_IDX_CALIB_CONTROL_B) begin
        calib_control_b <= wr_byte; // RULE10
      end else if (req_index == `DSC_IDX_CALIB_CONTROL_C) begin
        calib_control_c <= wr_byte; // RULE10
      end
    end
  end

  // datapath clock power; reset value keeps the clocks down
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      datapath_clock_power <= `DSC_RST_DATAPATH_CLK_PWR;
    end else if (wr_take && req_index == `DSC_IDX_DATAPATH_CLK_PWR) begin
      datapath_clock_power <= wr_byte;
    end
  end

  // bit 7 is status, bit 6 unused: only the mode field stores
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_mode_field <= 6'h00;
    end else if (wr_take && req_index == `DSC_IDX_LINK_MODE_SELECT) begin
      link_mode_field <= wr_byte[`DSC_MSB_LINK_MODE:0]; // RULE12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      interpolation_select <= `DSC_RST_INTERP;
    end else if (wr_take && req_index == `DSC_IDX_INTERP_SELECT) begin
      interpolation_select <= wr_byte; // RULE13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sysref_control <= `DSC_RST_ZERO;
    end else if (wr_take && req_index == `DSC_IDX_SYSREF_CONTROL) begin
      sysref_control <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_error_duration <= `DSC_RST_ZERO;
    end else if (wr_take && req_index == `DSC_IDX_SYNC_ERR_DURATION) begin
      sync_error_duration <= wr_byte; // RULE17
    end
  end

  // the valid set is coarse: a zero interpolation field or a serial
  // mode beyond the table is flagged; finer pairing is left to software
  always_comb begin
    next_invalid = 1'b0;
    if (link_mode_field[`DSC_MSB_SERIAL_MODE:0] > `DSC_MAX_SERIAL_MODE) begin
      next_invalid = 1'b1;
    end else if (interpolation_select[`DSC_MSB_MAIN_INTERP:`DSC_LSB_MAIN_INTERP]
                 == 4'h0) begin
      next_invalid = 1'b1;
    end else if (interpolation_select[`DSC_MSB_CHAN_INTERP:0] == 4'h0) begin
      next_invalid = 1'b1;
    end
  end

  // derived outputs, one register stage behind the stored fields;
  // clocks run only for the exact power-up code
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      datapath_clocks_on <= 1'b0;
    end else begin
      datapath_clocks_on <= (datapath_clock_power == `DSC_DATAPATH_CLK_ON); // RULE11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dual_link_mode      <= 1'b0;
      serial_link_mode    <= 5'h00;
      link_config_invalid <= 1'b1;
    end else begin
      dual_link_mode      <= link_mode_field[`DSC_BIT_DUAL_LINK]; // RULE12
      serial_link_mode    <= link_mode_field[`DSC_MSB_SERIAL_MODE:0]; // RULE12
      link_config_invalid <= next_invalid; // RULE14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      main_path_interp_select    <= 4'h0;
      channel_path_interp_select <= 4'h0;
    end else begin
      main_path_interp_select <=
        interpolation_select[`DSC_MSB_MAIN_INTERP:`DSC_LSB_MAIN_INTERP]; // RULE13
      channel_path_interp_select <=
        interpolation_select[`DSC_MSB_CHAN_INTERP:0]; // RULE13
    end
  end

  // powerdown is passed through; subclass policing is the host's
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sysref_coupling_select    <= 1'b0;
      sysref_receiver_powerdown <= 1'b0;
    end else begin
      sysref_coupling_select    <= sysref_control[`DSC_BIT_SYSREF_DC]; // RULE15
      sysref_receiver_powerdown <= sysref_control[`DSC_BIT_SYSREF_RECEIVER_POWERDOWN]; // RULE16
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_sync_output_err_len <= 4'h0;
    end else begin
      link_sync_output_err_len <=
        sync_error_duration[`DSC_MSB_SYNC_ERR:`DSC_LSB_SYNC_ERR]; // RULE17
    end
  end

endmodule

//--- sim/dsc_lock_model.sv
`timescale 1ns/10ps
// analog lock sources; pll stays unlocked until the first vco reset pulse
module dsc_lock_model #(
  parameter int LOCK_CYC = 40
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic vco_reset,
  input  wire logic dll_update_pulse,
  output logic      pll_locked,
  output logic      dll_locked
);
  logic armed;
  int   pcnt;
  int   dcnt;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      armed      <= 1'b0;
      pcnt       <= 0;
      pll_locked <= 1'b0;
    end else if (vco_reset) begin
      armed      <= 1'b1;
      pcnt       <= 0;
      pll_locked <= 1'b0;
    end else if (armed && pcnt < LOCK_CYC) begin
      pcnt <= pcnt + 1;
    end else if (armed) begin
      pll_locked <= 1'b1;
    end
  end
  // relock after every settings transfer
  always_ff @(posedge clk_sys) begin
    if (srst || dll_update_pulse) begin
      dcnt       <= 0;
      dll_locked <= 1'b0;
    end else if (dcnt < LOCK_CYC) begin
      dcnt <= dcnt + 1;
    end else begin
      dll_locked <= 1'b1;
    end
  end
endmodule

//--- sim/dsc_startup_config_chk.sv
`timescale 1ns/10ps
module dsc_startup_config_chk #(
  parameter int ADDR_W = 13
) (
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  input wire logic              vco_half_divide_enable,
  input wire logic              vco_third_divide_enable,
  input wire logic              dll_update_pulse,
  input wire logic              datapath_clocks_on,
  input wire logic              dual_link_mode,
  input wire logic [3:0]        main_path_interp_select,
  input wire logic              link_config_invalid,
  input wire logic              sysref_coupling_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_wr(int i);
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[ADDR_W-1:2] == i;
  endsequence
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest;
  endproperty
  property p_third; s_wr(11'h094) ##0 avs_writedata[1] |-> ##2 vco_third_divide_enable;
  endproperty
  property p_half; s_wr(11'h094) ##0 avs_writedata[1:0] == 2'b01 |-> ##2 vco_half_divide_enable;
  endproperty
  property p_pulse; dll_update_pulse |=> !dll_update_pulse; endproperty
  property p_dp_clk; s_wr(11'h100) ##0 avs_writedata[7:0] == 8'h00 |-> ##2 datapath_clocks_on;
  endproperty
  property p_link; s_wr(11'h110) |-> ##2 dual_link_mode == $past(avs_writedata[5], 2); endproperty
  property p_interp;
    s_wr(11'h111) |-> ##2 main_path_interp_select == $past(avs_writedata[7:4], 2);
  endproperty
  property p_invalid; s_wr(11'h110) ##0 avs_writedata[4:0] > 5'h13 |-> ##2 link_config_invalid;
  endproperty
  property p_sysref;
    s_wr(11'h084) |-> ##2 sysref_coupling_select == $past(avs_writedata[6], 2);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low over one cycle");
  a_answer: assert property (p_answer) else $error("bus request not answered");
  a_third: assert property (p_third) else $error("third divide not set");
  a_half: assert property (p_half) else $error("half divide not set");
  a_pulse: assert property (p_pulse) else $error("update pulse too long");
  a_dp_clk: assert property (p_dp_clk) else $error("datapath clocks off");
  a_link: assert property (p_link) else $error("dual link flag wrong");
  a_interp: assert property (p_interp) else $error("main interp wrong");
  a_invalid: assert property (p_invalid) else $error("invalid flag missing");
  a_sysref: assert property (p_sysref) else $error("sysref coupling wrong");
endmodule

//--- sim/dsc_startup_config_tb_top.sv
`timescale 1ns/10ps
module dsc_startup_config_tb_top
  import dsc_pkg::*;
();
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [12:0] avs_address = 13'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rdata;
  logic [7:0]  dl_pwr, dll_srch, cal_sa, cal_ca, cal_cb, cal_cc;
  logic [4:0]  ser_mode;
  logic [3:0]  main_ip, chan_ip, err_len;
  logic        avs_waitrequest, pll_locked, dll_locked, half_div, third_div, vco_reset;
  logic        upd_pulse, dp_on, dual, invalid, coupling, sr_pd;
  int          errors = 0;
  int          checks_done = 0;
  int          pulses = 0;
  dsc_startup_config #(.ADDR_W(13)) dut (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_locked(pll_locked),
    .dll_locked(dll_locked), .vco_half_divide_enable(half_div),
    .vco_third_divide_enable(third_div), .vco_reset(vco_reset),
    .delay_line_power_applied(dl_pwr), .dll_search_applied(dll_srch),
    .dll_update_pulse(upd_pulse), .calib_setting_a(cal_sa), .calib_control_a(cal_ca),
    .calib_control_b(cal_cb), .calib_control_c(cal_cc), .datapath_clocks_on(dp_on),
    .dual_link_mode(dual), .serial_link_mode(ser_mode), .main_path_interp_select(main_ip),
    .channel_path_interp_select(chan_ip), .link_config_invalid(invalid),
    .sysref_coupling_select(coupling), .sysref_receiver_powerdown(sr_pd),
    .link_sync_output_err_len(err_len));
  dsc_lock_model #(.LOCK_CYC(40)) u_lock (.clk_sys(clk_sys), .srst(srst),
    .vco_reset(vco_reset), .dll_update_pulse(upd_pulse), .pll_locked(pll_locked),
    .dll_locked(dll_locked));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // counted off the sampling edge so the one-cycle pulse is never missed
  always @(negedge clk_sys) if (upd_pulse === 1'b1) pulses++;
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input dsc_index_t i, input dsc_byte_t d);
    int n;
    n = 0;
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        errors++;
        $display("unexpected at %0t: bus hang", $time);
        print_verdict();
      end
      @(posedge clk_sys);
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  // extra edge lets derived outputs settle
  task automatic wr(input dsc_index_t i, input dsc_byte_t d);
    bus(1'b1, i, d);
    @(posedge clk_sys);
  endtask
  task automatic rdc(input dsc_index_t i, input dsc_byte_t exp);
    bus(1'b0, i, 8'h00);
    chk(rdata, {24'h000000, exp});
  endtask
  task automatic poll(input dsc_index_t i);
    int n;
    n = 0;
    bus(1'b0, i, 8'h00);
    while (rdata[0] !== 1'b1 && n < 100) begin
      n++;
      bus(1'b0, i, 8'h00);
    end
    chk(rdata[0], 1'b1);
    if (rdata[0] !== 1'b1) print_verdict();
  endtask
  task automatic t_reset();
    rdc(11'h110, 8'h80);
    rdc(11'h7B5, 8'h00);
    chk(dp_on, 1'b0);
    rdc(11'h7FF, 8'h00);
    rdc(11'h050, 8'h00);
    $display("done reset");
  endtask
  task automatic t_div();
    wr(11'h094, 8'h02);
    chk({half_div, third_div}, 2'b01);
    wr(11'h094, 8'h01);
    chk({half_div, third_div}, 2'b10);
    avs_byteenable <= 4'hE;
    wr(11'h094, 8'h02);
    chk({half_div, third_div}, 2'b10);
    avs_byteenable <= 4'hF;
    wr(11'h094, 8'h00);
    chk({half_div, third_div}, 2'b00);
    $display("done divider");
  endtask
  task automatic t_pll();
    wr(11'h792, 8'h02);
    chk(vco_reset, 1'b1);
    wr(11'h792, 8'h00);
    chk(vco_reset, 1'b0);
    poll(11'h7B5);
    $display("done pll");
  endtask
  task automatic t_dll();
    wr(11'h0C0, 8'h00);
    wr(11'h0DB, 8'h00);
    wr(11'h0DB, 8'h01);
    chk(pulses, 0);
    wr(11'h0DB, 8'h00);
    chk(pulses, 1);
    chk(dl_pwr, 8'h00);
    wr(11'h0C1, 8'h48);
    wr(11'h0C1, 8'h49);
    chk(dll_srch, 8'h00);
    wr(11'h0DB, 8'h01);
    wr(11'h0DB, 8'h00);
    chk(dll_srch, 8'h49);
    // let the dll relock so only the status gate can hide it
    repeat (48) @(posedge clk_sys);
    rdc(11'h0C3, 8'h00);
    wr(11'h0C7, 8'h01);
    poll(11'h0C3);
    $display("done dll");
  endtask
  task automatic t_cal();
    wr(11'h050, 8'h2A);
    wr(11'h061, 8'h68);
    wr(11'h051, 8'h82);
    wr(11'h051, 8'h83);
    wr(11'h081, 8'h03);
    chk({cal_sa, cal_ca, cal_cb, cal_cc}, 32'h2A688303);
    rdc(11'h051, 8'h00);
    $display("done calibration");
  endtask
  task automatic t_link();
    wr(11'h100, 8'h00);
    chk(dp_on, 1'b1);
    wr(11'h110, 8'h25);
    wr(11'h111, 8'h21);
    chk({dual, ser_mode}, 6'h25);
    chk({main_ip, chan_ip}, 8'h21);
    rdc(11'h110, 8'h25);
    wr(11'h110, 8'h14);
    rdc(11'h110, 8'h94);
    chk(invalid, 1'b1);
    wr(11'h110, 8'hC5);
    rdc(11'h110, 8'h05);
    wr(11'h084, 8'h41);
    chk({coupling, sr_pd}, 2'b11);
    wr(11'h312, 8'h50);
    chk(err_len, 4'h5);
    $display("done link");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_div();
    t_pll();
    t_dll();
    t_cal();
    t_link();
    print_verdict();
  end
endmodule
bind dsc_startup_config dsc_startup_config_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .vco_half_divide_enable(vco_half_divide_enable),
  .vco_third_divide_enable(vco_third_divide_enable), .dll_update_pulse(dll_update_pulse),
  .datapath_clocks_on(datapath_clocks_on), .dual_link_mode(dual_link_mode),
  .main_path_interp_select(main_path_interp_select), .link_config_invalid(link_config_invalid),
  .sysref_coupling_select(sysref_coupling_select));
